// ==== src/node_config_param_bank.sv ====
// What this block does
// - Wake bitmap: pulse, GPIO, serial, timer in bits 0-3; bit 7 beacon wait.
// - Config entry protection: none, timeout, two-step, or both.
// - Indicators go off after set minutes; 0 always off, 255 always on.
// - Command acknowledge only in packet mode and never on a gateway.
// - Shared pin is RTS input at 0, sleep input at 1.
// - Any nonzero status-on-connect write is stored as 1.
// - Dimmer starts at stored default duty, 0 to 100 percent.
// - Pulse mode bit 0 enables counter, bit 1 drops pull-up.
// - Pulse input debounced for set milliseconds; 0 disables it.
// - Connection change only when candidate RSSI beats current by margin.
// - Cluster formed once node count reaches limit 5 to 100.
// - Cluster RSSI threshold ranges from 40 to 100.
// - Gateway busy action after reset: ignore, halt and warn, warn.
// - Jamming alarm after continuous all-channel jamming for set minutes.
// - Alarm GPIO 0-7 driven low during alarm; 255 disables.
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module node_config_param_bank
  import node_cfg_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS,
  parameter int MIN_MS = MS_PER_MIN
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic is_end_device_i,
  input wire logic is_gateway_i,
  input wire logic packet_mode_i,
  input wire logic indicator_activity_i,
  input wire logic pulse_raw_i,
  input wire logic rts_sleep_pin_i,
  input wire logic rf_jammed_i,
  input wire logic net_activity_i,
  input wire logic [7:0] rssi_current_i,
  input wire logic [7:0] rssi_candidate_i,
  input wire logic [7:0] neighbour_rssi_i,
  input wire logic [7:0] neighbour_count_i,
  output logic [3:0] wake_sources_o,
  output logic beacon_wait_o,
  output logic [1:0] entry_security_o,
  output logic indicators_on_o,
  output logic neighbour_accept_o,
  output logic cmd_ack_active_o,
  output logic uart_rts_o,
  output logic sleep_req_o,
  output logic status_on_connect_o,
  output logic [7:0] dimmer_duty_o,
  output logic pulse_counter_on_o,
  output logic pullup_en_o,
  output logic pulse_clean_o,
  output logic conn_change_o,
  output logic cluster_o,
  output logic net_halt_o,
  output logic net_warn_o,
  output logic jam_alarm_o,
  output logic [NGPIO-1:0] alarm_gpio_o,
  output logic [NGPIO-1:0] alarm_gpio_oe_o
);
  initial begin
    if (MS_CYCLES < 2 || MIN_MS < 1) $error("node_config_param_bank: bad timing parameters");
  end

  // Strap caught once after reset release
  logic strap_done_reg, strap_done_next;
  logic [7:0] regs_reg [NREG];
  logic [7:0] regs_next [NREG];

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    return 8'(a[ADDR_W-1:2] - {2'b00, IDX_FIRST});
  endfunction : reg_index

  function automatic logic [7:0] reset_value(input int i);
    case (i)
      0: return RST_WAKE;
      1: return RST_ENTRY;
      2: return RST_IND_ROUTER;
      3: return RST_NEIGH;
      4: return RST_ACK;
      5: return RSVD_VALUE;
      6: return RST_PINFN;
      7: return RST_STCONN;
      8: return RST_DUTY;
      9: return RST_PCMODE;
      10: return RST_DEB;
      11: return RST_MARGIN;
      12: return RST_CLLIM;
      13: return RST_CLRSSI;
      14: return RST_BUSY;
      15: return RST_JAM;
      default: return RST_JGPIO;
    endcase
  endfunction : reset_value

  // Store-time cleanup keeps out-of-range writes from reaching the logic
  function automatic logic [7:0] sanitize(input int i, input logic [7:0] d, input logic [7:0] old);
    case (i)
      0: return d & WAKE_MASK;
      1: return {6'h0, d[1:0]};
      3, 4, 6: return {7'h0, d[0]};
      5: return RSVD_VALUE;
      7: return {7'h0, (d != 8'h0)};
      8: return (d > DUTY_MAX) ? RST_DUTY : d;
      9: return {6'h0, d[PC_NOPULL_BIT] & d[PC_ON_BIT], d[PC_ON_BIT]};
      12: return (d < CLLIM_MIN || d > CLLIM_MAX) ? old : d;
      13: return (d < CLRSSI_MIN || d > CLRSSI_MAX) ? old : d;
      14: return (d > BUSY_MAX) ? BUSY_MAX : d;
      15: return (d > JAM_MAX) ? old : d;
      16: return (d > JGPIO_MAX) ? JGPIO_OFF : d;
      default: return d;
    endcase
  endfunction : sanitize

  logic [7:0] idx;
  logic in_map, is_status, wr_en;
  logic [31:0] rdata_next;
  logic err_next;
  logic ready_next;

  always_comb begin
    idx = reg_index(paddr_i);
    in_map = (paddr_i[1:0] == 2'b00) && (paddr_i[ADDR_W-1:2] >= {2'b00, IDX_FIRST})
             && (idx < 8'(NREG));
    is_status = (paddr_i[ADDR_W-1:2] == {2'b00, IDX_STATUS}) && (paddr_i[1:0] == 2'b00);
    // Zero-wait slave: answer in the first access cycle
    ready_next = psel_i && !penable_i;
    wr_en = psel_i && penable_i && pready_o && pwrite_i && in_map && pstrb_i[0];
    err_next = ready_next && !in_map && !is_status;
    rdata_next = 32'h0;
    if (ready_next && !pwrite_i) begin
      if (in_map) begin
        rdata_next = {24'h0, regs_reg[idx[4:0]]};
      end else if (is_status) begin
        rdata_next = {24'h0, jam_alarm_o, net_warn_o, net_halt_o, cluster_o, conn_change_o,
                      pulse_clean_o, indicators_on_o, cmd_ack_active_o};
      end
    end
    strap_done_next = 1'b1;
    for (int i = 0; i < NREG; i++) begin
      regs_next[i] = regs_reg[i];
      if (!strap_done_reg && i == 2) begin
        regs_next[i] = is_end_device_i ? RST_IND_END : RST_IND_ROUTER;
      end else if (wr_en && idx == 8'(i)) begin
        regs_next[i] = sanitize(i, pwdata_i[7:0], regs_reg[i]);
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= reset_value(i);
      end
      strap_done_reg <= 1'b0;
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      strap_done_reg <= strap_done_next;
      prdata_o <= rdata_next;
      pready_o <= ready_next;
      pslverr_o <= err_next;
    end
  end

  // Shared millisecond and minute timebase
  logic ms_tick;
  ms_ticker #(.CYCLES(MS_CYCLES)) u_ms (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tick_o(ms_tick)
  );
  logic [31:0] min_cnt_reg, min_cnt_next;
  logic min_tick;
  always_comb begin
    min_tick = ms_tick && (min_cnt_reg == 32'(MIN_MS - 1));
    min_cnt_next = min_tick ? 32'h0 : (ms_tick ? min_cnt_reg + 32'h1 : min_cnt_reg);
  end

  // Indicator minutes, pulse debounce, jam minutes, busy state
  logic [7:0] ind_min_reg, ind_min_next;
  logic ind_on_next;
  logic [7:0] deb_cnt_reg, deb_cnt_next;
  logic pulse_last_reg, pulse_last_next;
  logic pulse_clean_next;
  logic [7:0] jam_min_reg, jam_min_next;
  logic jam_next;
  logic [NGPIO-1:0] jg_oe_next, jg_out_next;
  busy_state_t busy_reg, busy_next;
  logic busy_seen_reg, busy_seen_next;
  logic [7:0] ind_cfg, deb_cfg, jam_cfg, jg_cfg;

  always_comb begin
    ind_cfg = regs_reg[2];
    deb_cfg = regs_reg[10];
    jam_cfg = regs_reg[15];
    jg_cfg = regs_reg[16];
    // Activity restarts the minute count
    if (indicator_activity_i) begin
      ind_min_next = 8'h0;
    end else if (min_tick && ind_min_reg != 8'hff) begin
      ind_min_next = ind_min_reg + 8'h1;
    end else begin
      ind_min_next = ind_min_reg;
    end
    case (ind_cfg)
      IND_ALWAYS_OFF: ind_on_next = 1'b0;
      IND_ALWAYS_ON: ind_on_next = 1'b1;
      default: ind_on_next = ind_min_reg < ind_cfg;
    endcase
    // Input must stay unchanged for the set time before it is accepted
    pulse_last_next = pulse_raw_i;
    pulse_clean_next = pulse_clean_o;
    deb_cnt_next = deb_cnt_reg;
    if (deb_cfg == 8'h0) begin
      pulse_clean_next = pulse_raw_i;
      deb_cnt_next = 8'h0;
    end else if (pulse_raw_i != pulse_last_reg) begin
      deb_cnt_next = 8'h0;
    end else if (pulse_raw_i != pulse_clean_o && ms_tick) begin
      if (deb_cnt_reg + 8'h1 >= deb_cfg) begin
        pulse_clean_next = pulse_raw_i;
        deb_cnt_next = 8'h0;
      end else begin
        deb_cnt_next = deb_cnt_reg + 8'h1;
      end
    end
    // Any gap in jamming restarts the minute count
    if (!rf_jammed_i || jam_cfg == 8'h0) begin
      jam_min_next = 8'h0;
    end else if (min_tick && jam_min_reg < jam_cfg) begin
      jam_min_next = jam_min_reg + 8'h1;
    end else begin
      jam_min_next = jam_min_reg;
    end
    jam_next = rf_jammed_i && jam_cfg != 8'h0 && jam_min_reg >= jam_cfg;
    // Pin is driven high when idle, low during alarm; this block sets the output enable of the selected pin itself
    jg_oe_next = '0;
    jg_out_next = '1;
    for (int g = 0; g < NGPIO; g++) begin
      if (jg_cfg == 8'(g)) begin
        jg_oe_next[g] = 1'b1;
        jg_out_next[g] = !jam_next;
      end
    end
    // Only the first activity after reset counts
    busy_seen_next = busy_seen_reg || net_activity_i;
    busy_next = busy_reg;
    case (busy_reg)
      BUSY_IDLE: begin
        if (net_activity_i && !busy_seen_reg && is_gateway_i && packet_mode_i) begin
          case (regs_reg[14])
            8'h01: busy_next = BUSY_HALT;
            8'h02: busy_next = BUSY_WARN;
            default: busy_next = BUSY_IDLE;
          endcase
        end
      end
      BUSY_HALT: busy_next = BUSY_HALT;
      BUSY_WARN: busy_next = BUSY_WARN;
      default: busy_next = BUSY_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      min_cnt_reg <= 32'h0;
      ind_min_reg <= 8'h0;
      deb_cnt_reg <= 8'h0;
      pulse_last_reg <= 1'b0;
      pulse_clean_o <= 1'b0;
      jam_min_reg <= 8'h0;
      busy_reg <= BUSY_IDLE;
      busy_seen_reg <= 1'b0;
      indicators_on_o <= 1'b0;
      jam_alarm_o <= 1'b0;
      alarm_gpio_o <= '1;
      alarm_gpio_oe_o <= '0;
      net_halt_o <= 1'b0;
      net_warn_o <= 1'b0;
    end else begin
      min_cnt_reg <= min_cnt_next;
      ind_min_reg <= ind_min_next;
      deb_cnt_reg <= deb_cnt_next;
      pulse_last_reg <= pulse_last_next;
      pulse_clean_o <= pulse_clean_next;
      jam_min_reg <= jam_min_next;
      busy_reg <= busy_next;
      busy_seen_reg <= busy_seen_next;
      indicators_on_o <= ind_on_next;
      jam_alarm_o <= jam_next;
      alarm_gpio_o <= jg_out_next;
      alarm_gpio_oe_o <= jg_oe_next;
      net_halt_o <= (busy_next == BUSY_HALT);
      net_warn_o <= (busy_next != BUSY_IDLE);
    end
  end

  // Registered views of the stored settings
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_sources_o <= RST_WAKE[3:0];
      beacon_wait_o <= 1'b0;
      entry_security_o <= 2'b00;
      neighbour_accept_o <= 1'b0;
      cmd_ack_active_o <= 1'b0;
      uart_rts_o <= 1'b0;
      sleep_req_o <= 1'b0;
      status_on_connect_o <= 1'b0;
      dimmer_duty_o <= RST_DUTY;
      pulse_counter_on_o <= 1'b0;
      pullup_en_o <= 1'b0;
      conn_change_o <= 1'b0;
      cluster_o <= 1'b0;
    end else begin
      wake_sources_o <= regs_reg[0][WAKE_TIMER_BIT:WAKE_PULSE_BIT];
      beacon_wait_o <= regs_reg[0][WAKE_BEACON_BIT];
      entry_security_o <= regs_reg[1][1:0];
      neighbour_accept_o <= regs_reg[3][0];
      cmd_ack_active_o <= regs_reg[4][0] && packet_mode_i && !is_gateway_i;
      uart_rts_o <= !regs_reg[6][0] && rts_sleep_pin_i;
      sleep_req_o <= regs_reg[6][0] && rts_sleep_pin_i;
      status_on_connect_o <= regs_reg[7][0];
      dimmer_duty_o <= regs_reg[8];
      pulse_counter_on_o <= regs_reg[9][PC_ON_BIT];
      pullup_en_o <= regs_reg[9][PC_ON_BIT] && !regs_reg[9][PC_NOPULL_BIT];
      conn_change_o <= {1'b0, rssi_candidate_i} >= {1'b0, rssi_current_i} + {1'b0, regs_reg[11]}
                       && rssi_candidate_i > rssi_current_i;
      cluster_o <= neighbour_count_i >= regs_reg[12] && neighbour_rssi_i >= regs_reg[13];
    end
  end
endmodule : node_config_param_bank
`default_nettype wire

// ==== src/node_cfg_pkg.sv ====
`default_nettype none
package node_cfg_pkg;
  localparam int ADDR_W = 12;
  // Byte addresses on APB are four times the parameter address
  localparam logic [7:0] IDX_WAKE = 8'h57;
  localparam logic [7:0] IDX_ENTRY = 8'h58;
  localparam logic [7:0] IDX_IND = 8'h59;
  localparam logic [7:0] IDX_NEIGH = 8'h5a;
  localparam logic [7:0] IDX_ACK = 8'h5b;
  localparam logic [7:0] IDX_RSVD = 8'h5c;
  localparam logic [7:0] IDX_PINFN = 8'h5d;
  localparam logic [7:0] IDX_STCONN = 8'h5e;
  localparam logic [7:0] IDX_DUTY = 8'h5f;
  localparam logic [7:0] IDX_PCMODE = 8'h60;
  localparam logic [7:0] IDX_DEB = 8'h61;
  localparam logic [7:0] IDX_MARGIN = 8'h62;
  localparam logic [7:0] IDX_CLLIM = 8'h63;
  localparam logic [7:0] IDX_CLRSSI = 8'h64;
  localparam logic [7:0] IDX_BUSY = 8'h65;
  localparam logic [7:0] IDX_JAM = 8'h66;
  localparam logic [7:0] IDX_JGPIO = 8'h67;
  localparam logic [7:0] IDX_STATUS = 8'h68;
  localparam logic [7:0] IDX_FIRST = IDX_WAKE;
  localparam int NREG = 17;

  localparam logic [7:0] RST_WAKE = 8'h08;
  localparam logic [7:0] RST_ENTRY = 8'h00;
  localparam logic [7:0] RST_IND_ROUTER = 8'hff;
  localparam logic [7:0] RST_IND_END = 8'h01;
  localparam logic [7:0] RST_NEIGH = 8'h00;
  localparam logic [7:0] RST_ACK = 8'h01;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  localparam logic [7:0] RST_PINFN = 8'h00;
  localparam logic [7:0] RST_STCONN = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PCMODE = 8'h00;
  localparam logic [7:0] RST_DEB = 8'h00;
  localparam logic [7:0] RST_MARGIN = 8'h12;
  localparam logic [7:0] RST_CLLIM = 8'h0a;
  localparam logic [7:0] RST_CLRSSI = 8'h3c;
  localparam logic [7:0] RST_BUSY = 8'h00;
  localparam logic [7:0] RST_JAM = 8'h00;
  localparam logic [7:0] RST_JGPIO = 8'hff;

  localparam logic [7:0] WAKE_MASK = 8'h8f;
  localparam int WAKE_PULSE_BIT = 0;
  localparam int WAKE_GPIO_BIT = 1;
  localparam int WAKE_SERIAL_BIT = 2;
  localparam int WAKE_TIMER_BIT = 3;
  localparam int WAKE_BEACON_BIT = 7;
  localparam int PC_ON_BIT = 0;
  localparam int PC_NOPULL_BIT = 1;
  localparam logic [7:0] IND_ALWAYS_OFF = 8'h00;
  localparam logic [7:0] IND_ALWAYS_ON = 8'hff;
  localparam logic [7:0] DUTY_MAX = 8'h64;
  localparam logic [7:0] CLLIM_MIN = 8'h05;
  localparam logic [7:0] CLLIM_MAX = 8'h64;
  localparam logic [7:0] CLRSSI_MIN = 8'h28;
  localparam logic [7:0] CLRSSI_MAX = 8'h64;
  localparam logic [7:0] BUSY_MAX = 8'h02;
  localparam logic [7:0] JAM_MAX = 8'h64;
  localparam logic [7:0] JGPIO_MAX = 8'h07;
  localparam logic [7:0] JGPIO_OFF = 8'hff;

  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_MIN = 60_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int NGPIO = 8;
  localparam logic [31:0] SLVERR_NONE = 32'h0;

  typedef enum logic [2:0] {
    BUSY_IDLE = 3'b001,
    BUSY_HALT = 3'b010,
    BUSY_WARN = 3'b100
  } busy_state_t;
endpackage : node_cfg_pkg
`default_nettype wire

// ==== src/ms_ticker.sv ====
`default_nettype none
// Free-running divider giving a one-cycle pulse every CYCLES clocks
module ms_ticker #(
  parameter int CYCLES = 20000
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  output logic tick_o
);
  initial begin
    if (CYCLES < 2) $error("ms_ticker: CYCLES must be at least 2");
  end
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic tick_next;
  always_comb begin
    tick_next = (cnt_reg == 32'(CYCLES - 1));
    cnt_next = tick_next ? 32'h0 : cnt_reg + 32'h1;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= tick_next;
    end
  end
endmodule : ms_ticker
`default_nettype wire

// ==== bench/node_cfg_properties.sv ====
`default_nettype none
module node_cfg_checker
  import node_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic is_gateway_i,
  input wire logic packet_mode_i,
  input wire logic rts_sleep_pin_i,
  input wire logic [7:0] rssi_current_i,
  input wire logic [7:0] rssi_candidate_i,
  input wire logic [7:0] neighbour_rssi_i,
  input wire logic [7:0] neighbour_count_i,
  input wire logic cmd_ack_active_o,
  input wire logic uart_rts_o,
  input wire logic sleep_req_o,
  input wire logic [7:0] dimmer_duty_o,
  input wire logic conn_change_o,
  input wire logic cluster_o,
  input wire logic net_halt_o,
  input wire logic net_warn_o,
  input wire logic [NGPIO-1:0] alarm_gpio_o,
  input wire logic [NGPIO-1:0] alarm_gpio_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // Zero wait states: answer in the first access cycle
  property p_ready_setup;
    psel_i && !penable_i |=> pready_o ##1 !pready_o;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("pready late or long");
  property p_rdata_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_rsvd_read;
    psel_i && penable_i && !pwrite_i && paddr_i == 12'h170 |-> pready_o && prdata_o == 32'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte not zero");
  property p_ack_gate;
    cmd_ack_active_o |-> $past(packet_mode_i) && !$past(is_gateway_i);
  endproperty
  a_ack_gate: assert property (p_ack_gate) else $error("ack outside packet mode");
  property p_pin_route;
    uart_rts_o || sleep_req_o |-> $past(rts_sleep_pin_i) && !(uart_rts_o && sleep_req_o);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin routed wrongly");
  property p_duty_range;
    dimmer_duty_o <= 8'h64;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty above 100");
  property p_conn_change;
    conn_change_o |-> $past(rssi_candidate_i) > $past(rssi_current_i);
  endproperty
  a_conn_change: assert property (p_conn_change) else $error("change without better rssi");
  property p_cluster;
    cluster_o |-> $past(neighbour_count_i) >= 8'h05 && $past(neighbour_rssi_i) >= 8'h28;
  endproperty
  a_cluster: assert property (p_cluster) else $error("cluster below limits");
  property p_halt_warn;
    net_halt_o |-> net_warn_o;
  endproperty
  a_halt_warn: assert property (p_halt_warn) else $error("halt without warn");
  property p_gpio_alarm;
    $onehot0(alarm_gpio_oe_o) && (~alarm_gpio_o & ~alarm_gpio_oe_o) == 8'h00;
  endproperty
  a_gpio_alarm: assert property (p_gpio_alarm) else $error("alarm pin low unselected");
  c_cluster: cover property (cluster_o);
endmodule : node_cfg_checker
bind node_config_param_bank node_cfg_checker u_chk (.*);
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top import node_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rdat;
  logic [3:0] pstrb_i = 4'hf;
  logic is_end_device_i = 0, is_gateway_i = 0, packet_mode_i = 0, indicator_activity_i = 0;
  logic pulse_raw_i = 0, rts_sleep_pin_i = 0, rf_jammed_i = 0, net_activity_i = 0;
  logic [7:0] rssi_current_i = 0, rssi_candidate_i = 0, neighbour_rssi_i = 0, neighbour_count_i = 0;
  logic pready_o, pslverr_o, beacon_wait_o, indicators_on_o, neighbour_accept_o, cmd_ack_active_o, rerr;
  logic uart_rts_o, sleep_req_o, status_on_connect_o, pulse_counter_on_o, pullup_en_o, pulse_clean_o;
  logic conn_change_o, cluster_o, net_halt_o, net_warn_o, jam_alarm_o;
  logic [3:0] wake_sources_o;
  logic [1:0] entry_security_o;
  logic [7:0] dimmer_duty_o, alarm_gpio_o, alarm_gpio_oe_o;
  int n_fail = 0, checked = 0, cyc = 0;
  localparam logic [7:0] RV [17] = '{8'h08, 8'h00, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h12, 8'h0a, 8'h3c, 8'h00, 8'h00, 8'hff};
  // Address, write data, expected read-back
  localparam logic [23:0] SV [24] = '{24'h57ff8f, 24'h580703, 24'h5e0501, 24'h5f6464, 24'h5f6500,
    24'h600303, 24'h600200, 24'h61ffff, 24'h62ffff, 24'h630505, 24'h630405, 24'h636464, 24'h636564,
    24'h642828, 24'h642728, 24'h646464, 24'h646564, 24'h650702, 24'h666464, 24'h666564, 24'h670707,
    24'h6708ff, 24'h5caa00, 24'h5b0301};

  node_config_param_bank #(.MS_CYCLES(4), .MIN_MS(3)) dut (.*);

  always #25 clock_i = ~clock_i;

  task end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value t=%0t %s", $time, m);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr

  task rd(input logic [7:0] i, input logic [7:0] e, input string m);
    apb(1'b0, i, 8'h00);
    chk(rdat, {24'h0, e}, m);
  endtask : rd

  task wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wt

  task t_reset;
    chk(wake_sources_o, 4'h8, "wake after reset");
    chk(alarm_gpio_o, 8'hff, "gpio after reset");
    for (int i = 0; i < 17; i++) rd(8'h57 + i[7:0], RV[i], "reset value");
    apb(1'b0, 8'h70, 8'h00);
    chk(rerr, 1'b1, "unmapped no error");
  endtask : t_reset

  // Must run before any other network activity after reset
  task t_busy;
    wr(8'h65, 8'h01);
    is_gateway_i <= 1'b1;
    packet_mode_i <= 1'b1;
    wt(2);
    net_activity_i <= 1'b1;
    wt(2);
    net_activity_i <= 1'b0;
    wt(3);
    chk(net_halt_o, 1'b1, "busy halt");
    chk(net_warn_o, 1'b1, "busy warn");
  endtask : t_busy

  task t_sanitise;
    for (int i = 0; i < 24; i++) begin
      wr(SV[i][23:16], SV[i][15:8]);
      rd(SV[i][23:16], SV[i][7:0], "stored value");
    end
  endtask : t_sanitise

  task t_outputs;
    wr(8'h57, 8'h8b);
    wr(8'h58, 8'h02);
    wr(8'h5f, 8'h32);
    wr(8'h60, 8'h01);
    wr(8'h5d, 8'h01);
    wr(8'h59, 8'h00);
    rts_sleep_pin_i <= 1'b1;
    wt(3);
    chk(wake_sources_o, 4'hb, "wake bits");
    chk(beacon_wait_o, 1'b1, "beacon wait");
    chk(entry_security_o, 2'h2, "entry mode");
    chk(dimmer_duty_o, 8'h32, "duty");
    chk(pulse_counter_on_o, 1'b1, "counter on");
    chk(pullup_en_o, 1'b1, "pull-up on");
    chk(sleep_req_o, 1'b1, "sleep routing");
    chk(uart_rts_o, 1'b0, "rts idle");
    chk(indicators_on_o, 1'b0, "indicators off");
    chk(status_on_connect_o, 1'b1, "status on connect");
    wr(8'h60, 8'h03);
    wr(8'h5d, 8'h00);
    wr(8'h59, 8'hff);
    wt(3);
    chk(pullup_en_o, 1'b0, "pull-up off");
    chk(uart_rts_o, 1'b1, "rts routing");
    chk(sleep_req_o, 1'b0, "sleep idle");
    chk(indicators_on_o, 1'b1, "indicators on");
  endtask : t_outputs

  task t_ack;
    for (int i = 0; i < 4; i++) begin
      packet_mode_i <= i[0];
      is_gateway_i <= i[1];
      wt(3);
      chk(cmd_ack_active_o, i == 1, "ack gating");
    end
    is_gateway_i <= 1'b0;
  endtask : t_ack

  task t_link;
    wr(8'h62, 8'h12);
    wr(8'h63, 8'h0a);
    wr(8'h64, 8'h3c);
    rssi_current_i <= 8'h32;
    rssi_candidate_i <= 8'h43;
    neighbour_count_i <= 8'h0a;
    neighbour_rssi_i <= 8'h3c;
    wt(3);
    chk(conn_change_o, 1'b0, "margin minus one");
    chk(cluster_o, 1'b1, "cluster at limits");
    rssi_candidate_i <= 8'h44;
    neighbour_count_i <= 8'h09;
    wt(3);
    chk(conn_change_o, 1'b1, "margin met");
    chk(cluster_o, 1'b0, "count short");
    neighbour_count_i <= 8'h0a;
    neighbour_rssi_i <= 8'h3b;
    wt(3);
    chk(cluster_o, 1'b0, "rssi short");
  endtask : t_link

  // One minute is 12 cycles with the shortened counts
  task t_jam;
    wr(8'h66, 8'h01);
    wr(8'h67, 8'h03);
    rf_jammed_i <= 1'b1;
    wt(6);
    chk(jam_alarm_o, 1'b0, "alarm early");
    chk(alarm_gpio_o, 8'hff, "pin early");
    wt(30);
    chk(jam_alarm_o, 1'b1, "alarm raised");
    chk(alarm_gpio_o, 8'hf7, "pin low");
    chk(alarm_gpio_oe_o, 8'h08, "pin driven");
    rf_jammed_i <= 1'b0;
    wt(4);
    chk(alarm_gpio_o, 8'hff, "pin released");
  endtask : t_jam

  task t_deb;
    wr(8'h61, 8'h02);
    pulse_raw_i <= 1'b1;
    wt(3);
    pulse_raw_i <= 1'b0;
    wt(12);
    chk(pulse_clean_o, 1'b0, "glitch passed");
    pulse_raw_i <= 1'b1;
    wt(20);
    chk(pulse_clean_o, 1'b1, "pulse lost");
    wr(8'h61, 8'h00);
    pulse_raw_i <= 1'b0;
    wt(3);
    chk(pulse_clean_o, 1'b0, "no debounce");
  endtask : t_deb

  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset;
    t_busy;
    t_sanitise;
    t_outputs;
    t_ack;
    t_link;
    t_jam;
    t_deb;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
